// file: hdl/scs_pkg.sv
// constants and types shared by the sample clock source selector
package scs_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [27:0] CLK_HZ = 28'h5F5E100;
  localparam int GATE_TIME_US = 1000;
  localparam int GATE_CYCLES = (GATE_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // rate limits, in kHz per measurement window
  // ==========================================================================
  localparam logic [8:0] MIN_RATE_KHZ = 9'h01C;
  localparam logic [8:0] MAX_RATE_KHZ = 9'h0C8;
  localparam logic [8:0] SMUX_LO_KHZ  = 9'h058;
  localparam logic [8:0] SMUX_HI_KHZ  = 9'h060;
  localparam logic [8:0] SYNC_TOL_KHZ = 9'h001;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [4:0] OFS_CTRL       = 5'h00;
  localparam logic [4:0] OFS_BASE       = 5'h04;
  localparam logic [4:0] OFS_COARSE     = 5'h08;
  localparam logic [4:0] OFS_FINE       = 5'h0C;
  localparam logic [4:0] OFS_STATUS     = 5'h10;
  localparam logic [4:0] OFS_RATE       = 5'h14;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h1C;

  // ==========================================================================
  // control field positions and reset values
  // ==========================================================================
  localparam int CTRL_AUTO       = 0;
  localparam int CTRL_PREF_LSB   = 1;
  localparam int CTRL_SYN_EN     = 3;
  localparam int CTRL_COARSE_ACT = 4;
  localparam int CTRL_FINE_ACT   = 5;
  localparam int CTRL_MULT_LSB   = 6;
  localparam int CTRL_BASE48     = 8;
  localparam logic [8:0]  CTRL_RST   = 9'h001;
  localparam logic [19:0] BASE_RST   = 20'h0BB80;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [21:0] INT44_HZ   = 22'h00AC44;
  localparam logic [21:0] INT48_HZ   = 22'h00BB80;
  localparam int IRQ_BITS = 5;

  // ==========================================================================
  // codes
  // ==========================================================================
  localparam logic [1:0] REF_WORD  = 2'h0;
  localparam logic [1:0] REF_OPT   = 2'h1;
  localparam logic [1:0] REF_SPDIF = 2'h2;
  localparam logic [1:0] REF_NONE  = 2'h3;
  localparam logic [1:0] MULT_DOUBLE = 2'h1;
  localparam logic [1:0] MULT_QUAD   = 2'h2;
  localparam logic [1:0] IN_NONE = 2'h0;
  localparam logic [1:0] IN_LOCK = 2'h1;
  localparam logic [1:0] IN_SYNC = 2'h2;

  typedef enum logic [3:0] {
    SRC_INTERNAL = 4'b0001,
    SRC_WORD     = 4'b0010,
    SRC_OPT      = 4'b0100,
    SRC_SPDIF    = 4'b1000
  } scs_src_type;

endpackage

// file: hdl/scs_input_monitor.sv
// one recovered clock input: synchroniser, edge finder, rate meter, lock and sync state
`timescale 1ns/1ps
module scs_input_monitor (
  input  wire logic       clk_in,        // system clock
  input  wire logic       reset_in,      // synchronous reset
  input  wire logic       ce_in,         // clock enable
  input  wire logic       pin_in,        // recovered frame clock pin
  input  wire logic       gate_in,       // end of measurement window
  input  wire logic [8:0] expect_khz_in, // expected frame rate
  output logic            edge_out,      // rising frame edge pulse
  output logic [8:0]      rate_khz_out,  // measured frame rate
  output logic [1:0]      state_out      // none, lock or sync
);

  logic       s1;
  logic       s2;
  logic       s3;
  logic       level;
  logic [8:0] cnt;
  logic       locked;
  logic [8:0] diff;

  // ==========================================================================
  // three-stage synchroniser, change accepted when stages two and three agree
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce_in) begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      level    <= 1'b0;
      edge_out <= 1'b0;
    end else if (ce_in) begin
      if (s2 == s3 && s3 != level) begin
        level    <= s3;
        edge_out <= s3;
      end else begin
        edge_out <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // edges per window give the frame rate in kHz
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt          <= 9'h000;
      rate_khz_out <= 9'h000;
    end else if (ce_in) begin
      if (gate_in) begin
        rate_khz_out <= cnt;
        cnt          <= edge_out ? 9'h001 : 9'h000;
      end else if (edge_out && cnt != 9'h1FF) begin
        cnt <= cnt + 9'h001;
      end
    end
  end

  // ==========================================================================
  // three-way state
  // ==========================================================================
  assign locked = rate_khz_out >= scs_pkg::MIN_RATE_KHZ &&
                  rate_khz_out <= scs_pkg::MAX_RATE_KHZ; // [R11]
  assign diff   = rate_khz_out >= expect_khz_in ? rate_khz_out - expect_khz_in
                                                : expect_khz_in - rate_khz_out;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_out <= scs_pkg::IN_NONE;
    end else if (ce_in) begin
      if (!locked) begin
        state_out <= scs_pkg::IN_NONE; // [R9]
      end else if (diff <= scs_pkg::SYNC_TOL_KHZ) begin
        state_out <= scs_pkg::IN_SYNC; // [R10]
      end else begin
        state_out <= scs_pkg::IN_LOCK; // [R10]
      end
    end
  end

endmodule

// file: hdl/scs_rate_synth.sv
// rate synthesizer: base rate times multiplier plus the active offsets, in Hz
`timescale 1ns/1ps
module scs_rate_synth (
  input  wire logic        clk_in,       // system clock
  input  wire logic        reset_in,     // synchronous reset
  input  wire logic        ce_in,        // clock enable
  input  wire logic [19:0] base_hz_in,   // base rate in Hz
  input  wire logic [1:0]  mult_in,      // speed range
  input  wire logic [15:0] coarse_in,    // signed coarse offset in Hz
  input  wire logic [15:0] fine_in,      // signed fine offset in Hz
  input  wire logic        coarse_act_in, // coarse offset active
  input  wire logic        fine_act_in,  // fine offset active
  output logic [21:0]      rate_hz_out   // synthesized rate in Hz
);

  logic [21:0]        scaled;
  logic signed [23:0] sum;

  always_comb begin
    unique case (mult_in)
      scs_pkg::MULT_DOUBLE: scaled = {1'b0, base_hz_in, 1'b0}; // [R16] [R17]
      scs_pkg::MULT_QUAD:   scaled = {base_hz_in, 2'b00}; // [R16] [R17]
      default:              scaled = {2'b00, base_hz_in}; // [R17]
    endcase
  end

  // offsets in 1 Hz steps, each only when its flag is set
  always_comb begin
    sum = $signed({2'b00, scaled}); // [R15]
    if (coarse_act_in) begin
      sum = sum + $signed({{8{coarse_in[15]}}, coarse_in}); // [R18] [R19]
    end
    if (fine_act_in) begin
      sum = sum + $signed({{8{fine_in[15]}}, fine_in}); // [R18] [R19]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rate_hz_out <= 22'h000000;
    end else if (ce_in) begin
      if (sum[23]) begin
        rate_hz_out <= 22'h000000;
      end else if (sum[22]) begin
        rate_hz_out <= 22'h3FFFFF;
      end else begin
        rate_hz_out <= sum[21:0];
      end
    end
  end

endmodule

// file: hdl/scs_selector.sv
// sample clock source selector top: registers, source choice, sample tick, interrupts
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// [R1] auto mode slaves to a valid input
// [R2] reference loss returns to internal clock
// [R3] master mode always uses internal clock
// [R4] preferred input wins while it is valid
// [R5] otherwise first valid input is used
// [R6] only word, optical, spdif are candidates
// [R7] no valid input means master mode
// [R8] report active reference and its rate
// [R9] each input: none, lock or sync
// [R10] sync needs lock plus matching frame rate
// [R11] lock range 28 to 200 kHz
// [R12] optical preferred at 88.2/96 kHz multiplexes
// [R13] multiplexed optical frames at half rate
// [R14] synthesizer only when enabled and master
// [R15] rate is base times multiplier plus offset
// [R16] multiplier picks single, double, quad speed
// [R17] multiplier scales by one, two, four
// [R18] offsets step in 1 Hz
// [R19] each offset has its own activation flag
module scs_selector #(
  parameter int GATE_CYCLES = scs_pkg::GATE_CYCLES
) (
  input  wire logic        clk_in,          // system clock, 100 MHz
  input  wire logic        reset_in,        // synchronous reset, active high
  input  wire logic        ce_in,           // clock enable, freezes state when low
  input  wire logic        word_clk_in,     // word clock input pin
  input  wire logic        opt_clk_in,      // optical recovered frame clock pin
  input  wire logic        spdif_clk_in,    // spdif recovered frame clock pin
  input  wire logic [4:0]  addr_in,         // register byte address
  input  wire logic [31:0] wdata_in,        // write data
  input  wire logic        wr_in,           // write strobe
  input  wire logic        rd_in,           // read strobe
  output logic [31:0]      rdata_out,       // read data, cycle after the strobe
  output logic             irq_out,         // level interrupt
  output logic             slave_out,       // high while clocked from an input
  output logic [1:0]       clk_src_out,     // active reference code
  output logic             sample_tick_out, // one pulse per system frame, one per two system frames when clocked from a multiplexed optical input
  output logic             smux_out         // optical port multiplexed
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [8:0]  ctrl;
  logic [19:0] base_hz;
  logic [15:0] coarse;
  logic [15:0] fine;
  logic [scs_pkg::IRQ_BITS-1:0] irq_status;
  logic [scs_pkg::IRQ_BITS-1:0] irq_mask;
  logic [scs_pkg::IRQ_BITS-1:0] irq_event;
  logic [16:0] gate_cnt;
  logic        gate;
  logic [8:0]  tick_cnt;
  logic [8:0]  sys_khz;
  logic [8:0]  opt_expect;
  logic [2:0]  edges;
  logic [8:0]  rate_khz [3];
  logic [1:0]  in_state [3];
  logic [1:0]  prev_state [3];
  logic [2:0]  valid;
  logic [21:0] synth_hz;
  logic [21:0] master_hz;
  logic [26:0] acc;
  logic [27:0] acc_sum;
  logic        int_tick;
  logic        next_tick;
  logic        next_smux;
  logic [8:0]  active_khz;
  logic [1:0]  pref;
  logic        auto_mode;
  logic        synth_on;
  scs_pkg::scs_src_type src;
  scs_pkg::scs_src_type next_src;

  assign auto_mode = ctrl[scs_pkg::CTRL_AUTO];
  assign pref      = ctrl[scs_pkg::CTRL_PREF_LSB +: 2];

  // ==========================================================================
  // register writes
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl     <= scs_pkg::CTRL_RST;
      base_hz  <= scs_pkg::BASE_RST;
      coarse   <= scs_pkg::OFFSET_RST;
      fine     <= scs_pkg::OFFSET_RST;
      irq_mask <= '0;
    end else if (ce_in && wr_in) begin
      unique case (addr_in)
        scs_pkg::OFS_CTRL:     ctrl     <= wdata_in[8:0];
        scs_pkg::OFS_BASE:     base_hz  <= wdata_in[19:0];
        scs_pkg::OFS_COARSE:   coarse   <= wdata_in[15:0];
        scs_pkg::OFS_FINE:     fine     <= wdata_in[15:0];
        scs_pkg::OFS_IRQ_MASK: irq_mask <= wdata_in[scs_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // register reads, data stand one cycle only
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      rdata_out <= 32'h00000000;
      if (rd_in) begin
        unique case (addr_in)
          scs_pkg::OFS_CTRL:       rdata_out <= {23'h000000, ctrl};
          scs_pkg::OFS_BASE:       rdata_out <= {12'h000, base_hz};
          scs_pkg::OFS_COARSE:     rdata_out <= {16'h0000, coarse};
          scs_pkg::OFS_FINE:       rdata_out <= {16'h0000, fine};
          scs_pkg::OFS_STATUS:     rdata_out <= {22'h000000, smux_out,
                                                 in_state[2], in_state[1], in_state[0],
                                                 clk_src_out, slave_out}; // [R8] [R9]
          scs_pkg::OFS_RATE:       rdata_out <= {7'h00, synth_hz[21:16], sys_khz,
                                                 1'b0, active_khz}; // [R8]
          scs_pkg::OFS_IRQ_STATUS: rdata_out <= {27'h0000000, irq_status};
          scs_pkg::OFS_IRQ_MASK:   rdata_out <= {27'h0000000, irq_mask};
          default:                 rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================================
  // measurement window
  // ==========================================================================
  assign gate = gate_cnt == 17'(GATE_CYCLES - 1);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gate_cnt <= 17'h00000;
    end else if (ce_in) begin
      gate_cnt <= gate ? 17'h00000 : gate_cnt + 17'h00001;
    end
  end

  // ==========================================================================
  // the three candidate inputs
  // ==========================================================================
  // optical frames run at half the system rate when multiplexed
  assign opt_expect = smux_out ? {1'b0, sys_khz[8:1]} : sys_khz; // [R13]

  scs_input_monitor u_word (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .pin_in        (word_clk_in),
    .gate_in       (gate),
    .expect_khz_in (sys_khz),
    .edge_out      (edges[0]),
    .rate_khz_out  (rate_khz[0]),
    .state_out     (in_state[0])
  );

  scs_input_monitor u_opt (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .pin_in        (opt_clk_in),
    .gate_in       (gate),
    .expect_khz_in (opt_expect),
    .edge_out      (edges[1]),
    .rate_khz_out  (rate_khz[1]),
    .state_out     (in_state[1])
  );

  scs_input_monitor u_spdif (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .pin_in        (spdif_clk_in),
    .gate_in       (gate),
    .expect_khz_in (sys_khz),
    .edge_out      (edges[2]),
    .rate_khz_out  (rate_khz[2]),
    .state_out     (in_state[2])
  );

  assign valid = {in_state[2] != scs_pkg::IN_NONE,
                  in_state[1] != scs_pkg::IN_NONE,
                  in_state[0] != scs_pkg::IN_NONE};

  // ==========================================================================
  // source choice
  // ==========================================================================
  always_comb begin
    next_src = scs_pkg::SRC_INTERNAL; // [R3] [R7] [R2]
    if (auto_mode) begin
      if (pref != scs_pkg::REF_NONE && valid[pref]) begin
        unique case (pref)
          scs_pkg::REF_WORD: next_src = scs_pkg::SRC_WORD; // [R4]
          scs_pkg::REF_OPT:  next_src = scs_pkg::SRC_OPT; // [R4]
          default:           next_src = scs_pkg::SRC_SPDIF; // [R4]
        endcase
      end else if (valid[0]) begin
        next_src = scs_pkg::SRC_WORD; // [R5] [R6] [R1]
      end else if (valid[1]) begin
        next_src = scs_pkg::SRC_OPT; // [R5] [R6] [R1]
      end else if (valid[2]) begin
        next_src = scs_pkg::SRC_SPDIF; // [R5] [R6] [R1]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      src <= scs_pkg::SRC_INTERNAL;
    end else if (ce_in) begin
      src <= next_src;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slave_out   <= 1'b0;
      clk_src_out <= scs_pkg::REF_NONE;
    end else if (ce_in) begin
      slave_out <= src != scs_pkg::SRC_INTERNAL; // [R1] [R2]
      unique case (src)
        scs_pkg::SRC_WORD:  clk_src_out <= scs_pkg::REF_WORD; // [R8]
        scs_pkg::SRC_OPT:   clk_src_out <= scs_pkg::REF_OPT; // [R8]
        scs_pkg::SRC_SPDIF: clk_src_out <= scs_pkg::REF_SPDIF; // [R8]
        default:            clk_src_out <= scs_pkg::REF_NONE;
      endcase
    end
  end

  always_comb begin
    unique case (src)
      scs_pkg::SRC_WORD:  active_khz = rate_khz[0];
      scs_pkg::SRC_OPT:   active_khz = rate_khz[1];
      scs_pkg::SRC_SPDIF: active_khz = rate_khz[2];
      default:            active_khz = sys_khz;
    endcase
  end

  // ==========================================================================
  // internal clock: fixed rate or synthesizer, phase accumulator
  // ==========================================================================
  scs_rate_synth u_synth (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .base_hz_in    (base_hz),
    .mult_in       (ctrl[scs_pkg::CTRL_MULT_LSB +: 2]),
    .coarse_in     (coarse),
    .fine_in       (fine),
    .coarse_act_in (ctrl[scs_pkg::CTRL_COARSE_ACT]),
    .fine_act_in   (ctrl[scs_pkg::CTRL_FINE_ACT]),
    .rate_hz_out   (synth_hz)
  );

  assign synth_on  = ctrl[scs_pkg::CTRL_SYN_EN] && src == scs_pkg::SRC_INTERNAL; // [R14]
  assign master_hz = synth_on ? synth_hz :
                     (ctrl[scs_pkg::CTRL_BASE48] ? scs_pkg::INT48_HZ : scs_pkg::INT44_HZ);
  assign acc_sum   = {1'b0, acc} + {6'h00, master_hz};
  assign int_tick  = acc_sum >= scs_pkg::CLK_HZ;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc <= 27'h0000000;
    end else if (ce_in) begin
      acc <= int_tick ? 27'(acc_sum - scs_pkg::CLK_HZ) : acc_sum[26:0];
    end
  end

  // ==========================================================================
  // system frame tick and its measured rate
  // ==========================================================================
  always_comb begin
    unique case (src)
      scs_pkg::SRC_WORD:  next_tick = edges[0];
      scs_pkg::SRC_OPT:   next_tick = edges[1];
      scs_pkg::SRC_SPDIF: next_tick = edges[2];
      default:            next_tick = int_tick; // [R3]
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sample_tick_out <= 1'b0;
    end else if (ce_in) begin
      sample_tick_out <= next_tick;
    end
  end

  // a multiplexed optical frame carries two system frames
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_cnt <= 9'h000;
      sys_khz  <= 9'h000;
    end else if (ce_in) begin
      if (gate) begin
        sys_khz  <= tick_cnt;
        tick_cnt <= 9'h000;
      end else if (sample_tick_out && tick_cnt < 9'h1FE) begin
        tick_cnt <= tick_cnt + ((smux_out && src == scs_pkg::SRC_OPT) ? 9'h002
                                                                      : 9'h001); // [R13]
      end
    end
  end

  assign next_smux = pref == scs_pkg::REF_OPT &&
                     sys_khz >= scs_pkg::SMUX_LO_KHZ &&
                     sys_khz <= scs_pkg::SMUX_HI_KHZ; // [R12]

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      smux_out <= 1'b0;
    end else if (ce_in) begin
      smux_out <= next_smux; // [R12] [R13]
    end
  end

  // ==========================================================================
  // interrupts: source change, mode change, per-input lock loss
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_state <= '{scs_pkg::IN_NONE, scs_pkg::IN_NONE, scs_pkg::IN_NONE};
    end else if (ce_in) begin
      prev_state <= in_state;
    end
  end

  always_comb begin
    irq_event[0] = next_src != src;
    irq_event[1] = (next_src == scs_pkg::SRC_INTERNAL) != (src == scs_pkg::SRC_INTERNAL);
    for (int i = 0; i < 3; i++) begin
      irq_event[i + 2] = prev_state[i] != scs_pkg::IN_NONE && in_state[i] == scs_pkg::IN_NONE;
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_status <= '0;
    end else if (ce_in) begin
      if (wr_in && addr_in == scs_pkg::OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wdata_in[scs_pkg::IRQ_BITS-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

endmodule

// file: verif/scs_frame_source.sv
// recovered frame clock source standing in for one external sender
`timescale 1ns/1ps
module scs_frame_source (
  input  wire logic       en_in,      // sender present
  input  wire logic [7:0] half_ns_in, // half period in ns
  output logic            pin_out     // frame clock pin
);
  logic live;
  initial begin
    pin_out = 1'b0;
    live    = 1'b0;
    forever begin
      #(half_ns_in);
      // a sender that goes away leaves the pin at the inverse of its last level
      if (en_in || live) pin_out = ~pin_out;
      live = en_in;
    end
  end
endmodule

// file: verif/scs_selector_properties.sv
// port checker for the sample clock source selector
`timescale 1ns/1ps
module scs_selector_properties (
  input wire logic        clk_in,          // system clock
  input wire logic        reset_in,        // synchronous reset
  input wire logic        word_clk_in,     // word clock pin
  input wire logic [4:0]  addr_in,         // register address
  input wire logic        rd_in,           // read strobe
  input wire logic [31:0] rdata_out,       // read data
  input wire logic        slave_out,       // slaved to an input
  input wire logic [1:0]  clk_src_out,     // active reference
  input wire logic        sample_tick_out  // frame pulse
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_status_read;
    rd_in && addr_in == 5'h10;
  endsequence
  sequence s_word_edge;
    $rose(word_clk_in) && slave_out && clk_src_out == 2'h0;
  endsequence
  // word must stay the source until its edge reaches the tick
  sequence s_word_held;
    (slave_out && clk_src_out == 2'h0) [*5];
  endsequence
  chk_master_internal: assert property (!slave_out |-> clk_src_out == 2'h3)
    else $error("master without internal source");
  chk_slave_candidate: assert property (slave_out |-> clk_src_out != 2'h3)
    else $error("slave without input source");
  chk_reset_state: assert property ($fell(reset_in) |-> clk_src_out == 2'h3 && !slave_out)
    else $error("reset state wrong");
  chk_src_hold: assert property ($changed(clk_src_out) |=> $stable(clk_src_out) [*8])
    else $error("source changed twice");
  chk_tick_single: assert property (sample_tick_out |=> !sample_tick_out)
    else $error("frame pulse too long");
  chk_word_tick: assert property (s_word_edge ##1 s_word_held |-> ##[0:3] sample_tick_out)
    else $error("no frame pulse after word edge");
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside answer cycle");
  chk_status_ref: assert property (s_status_read |=>
    rdata_out[2:0] == {$past(clk_src_out), $past(slave_out)})
    else $error("status disagrees with outputs");
endmodule
bind scs_selector scs_selector_properties scs_selector_properties_inst (
  .clk_in(clk_in), .reset_in(reset_in), .word_clk_in(word_clk_in), .addr_in(addr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .slave_out(slave_out), .clk_src_out(clk_src_out),
  .sample_tick_out(sample_tick_out));

// file: verif/tb_scs_selector.sv
// self-checking bench for the sample clock source selector
`timescale 1ns/1ps
module tb_scs_selector;
  localparam int GATE = 400;
  logic        clk_in, reset_in, wr_in, rd_in, irq_out, slave_out, sample_tick_out, smux_out;
  logic [4:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic [1:0]  clk_src_out;
  logic [2:0]  en, pins;
  logic [7:0]  sp_half;
  // row: ctrl[20:12] enables[11:9] slave[8] source[7:6] synth rate bits[5:0]
  logic [20:0] rows [11];
  int          err_count, checks;
  scs_frame_source scs_frame_source_inst [2:0] (.en_in(en),
    .half_ns_in({sp_half, 8'h3C, 8'h28}), .pin_out(pins));
  scs_selector #(.GATE_CYCLES(GATE)) scs_selector_inst (.clk_in(clk_in),
    .reset_in(reset_in), .ce_in(1'b1), .word_clk_in(pins[0]), .opt_clk_in(pins[1]),
    .spdif_clk_in(pins[2]), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .slave_out(slave_out),
    .clk_src_out(clk_src_out), .sample_tick_out(sample_tick_out), .smux_out(smux_out));
  // ==========================================================================
  // bus tasks and verdict
  // ==========================================================================
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #500000;
    err_count++;
    report_and_stop();
  end
  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    {reset_in, wr_in, rd_in, addr_in, wdata_in, en} = {1'b1, 42'h0};
    sp_half = 8'h14;
    rows = '{21'h001F00, 21'h003F40, 21'h005F80, 21'h001D40, 21'h007980, 21'h0010C0,
             21'h000EC0, 21'h088EC2, 21'h048EC1, 21'h018EC1, 21'h008EC0};
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(5'h00);
    chk(d, 32'h001);
    wr(5'h08, 32'h4E20);
    foreach (rows[i]) begin
      wr(5'h00, {23'h0, rows[i][20:12]});
      en <= rows[i][11:9];
      repeat (3 * GATE + 20) @(posedge clk_in);
      chk({31'h0, slave_out}, {31'h0, rows[i][8]});
      chk({30'h0, clk_src_out}, {30'h0, rows[i][7:6]});
      rd(5'h14);
      chk({26'h0, d[24:19]}, {26'h0, rows[i][5:0]});
    end
    sp_half <= 8'h50;
    wr(5'h1C, 32'h0);
    wr(5'h18, 32'h1F);
    wr(5'h00, 32'h001);
    repeat (5 * GATE) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    rd(5'h10);
    chk({26'h0, d[8:3]}, 32'h06);
    rd(5'h14);
    chk({23'h0, d[8:0]}, 32'h032);
    rd(5'h18);
    chk({31'h0, d[0]}, 32'h1);
    wr(5'h1C, 32'h1);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(5'h18, 32'h1);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    rd(5'h03);
    chk(d, 32'h0);
    // spdif alone near 91 frames per window, optical preferred
    en      <= 3'b100;
    sp_half <= 8'h16;
    repeat (3 * GATE) @(posedge clk_in);
    wr(5'h00, 32'h003);
    repeat (2 * GATE) @(posedge clk_in);
    #1;
    chk({30'h0, smux_out, slave_out}, 32'h3);
    // reset in mid-run returns to the internal clock
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk({28'h0, smux_out, slave_out, clk_src_out}, 32'h3);
    report_and_stop();
  end
endmodule
